// *** rtl/prx_pkg.sv ***
package prx_pkg;

   // register indices (word addresses on the register port)
   localparam logic [7:0] PRX_ADDR_FRAME_SIZE   = 8'hC0;
   localparam logic [7:0] PRX_ADDR_RX_DATA_POP  = 8'hC1;
   localparam logic [7:0] PRX_ADDR_RX_FRAMES    = 8'hD0;
   localparam logic [7:0] PRX_ADDR_RX_BCAST     = 8'hD1;
   localparam logic [7:0] PRX_ADDR_RX_MCAST     = 8'hD2;
   localparam logic [7:0] PRX_ADDR_RX_UCAST     = 8'hD3;
   localparam logic [7:0] PRX_ADDR_RX_FCS_ERR   = 8'hD4;
   localparam logic [7:0] PRX_ADDR_RX_ALIGN_ERR = 8'hD5;
   localparam logic [7:0] PRX_ADDR_RX_LEN_ERR   = 8'hD6;
   localparam logic [7:0] PRX_ADDR_RX_PHY_ERR   = 8'hD7;
   localparam logic [7:0] PRX_ADDR_TX_FRAMES    = 8'hD8;
   localparam logic [7:0] PRX_ADDR_TX_BCAST     = 8'hD9;
   localparam logic [7:0] PRX_ADDR_TX_MCAST     = 8'hDA;
   localparam logic [7:0] PRX_ADDR_TX_UCAST     = 8'hDB;
   localparam logic [7:0] PRX_ADDR_RX_FULL_DROP = 8'hDC;

   localparam int          PRX_NUM_TALLY   = 13;
   localparam logic [31:0] PRX_TALLY_RESET = 32'h0000_0000;
   localparam logic [31:0] PRX_DATA_RESET  = 32'h0000_0000;
   localparam int          PRX_SIZE_W      = 11;
   localparam int          PRX_FIFO_DEPTH  = 16;

   // tally indices, in register order
   localparam int PRX_T_RX_FRM   = 0;
   localparam int PRX_T_RX_BC    = 1;
   localparam int PRX_T_RX_MC    = 2;
   localparam int PRX_T_RX_UC    = 3;
   localparam int PRX_T_RX_FCS   = 4;
   localparam int PRX_T_RX_ALIGN = 5;
   localparam int PRX_T_RX_LEN   = 6;
   localparam int PRX_T_RX_PHY   = 7;
   localparam int PRX_T_TX_FRM   = 8;
   localparam int PRX_T_TX_BC    = 9;
   localparam int PRX_T_TX_MC    = 10;
   localparam int PRX_T_TX_UC    = 11;
   localparam int PRX_T_RX_DROP  = 12;

   // one received-frame outcome, one-cycle strobe
   typedef struct packed {
      logic valid;
      logic broadcast;
      logic multicast;
      logic fcs_err;
      logic phy_err;
      logic align_err;
      logic length_err;
      logic flooded;
      logic host_fifo_full;
      logic port_fifo_full;
   } prx_rx_event_t;

   // one transmitted-frame outcome, one-cycle strobe
   typedef struct packed {
      logic valid;
      logic broadcast;
      logic multicast;
   } prx_tx_event_t;

   // one word entering the host receive FIFO
   typedef struct packed {
      logic [31:0] data;
      logic        last;
   } prx_word_t;

   // register port request
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic       generic_spi;
   } prx_reg_req_t;

endpackage

// *** rtl/prx_fifo.sv ***
`timescale 1ns/10ps
module prx_fifo
#(
   parameter int WIDTH = 33,
   parameter int DEPTH = 16
)
(
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output      logic             in_ready,
   output      logic [WIDTH-1:0] out_data,
   output      logic             out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_q;
   logic [AW-1:0]    rd_ptr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign in_ready  = (count_q != (AW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rd_ptr_q];

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// *** rtl/prx_rx_pop_stats.sv ***
`timescale 1ns/10ps
module prx_rx_pop_stats
   import prx_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire prx_reg_req_t          reg_req,
   output      logic [31:0]           reg_rdata,
   output      logic                  reg_rvalid,
   input  wire prx_word_t             rx_word,
   input  wire logic                  rx_word_valid,
   output      logic                  rx_word_ready,
   input  wire logic [PRX_SIZE_W-1:0] head_frame_byte_length,
   input  wire prx_rx_event_t         rx_event,
   input  wire prx_tx_event_t         tx_event
);

   // ------------------------------------------------------------
   // receive FIFO
   // ------------------------------------------------------------
   prx_word_t   head_word;
   logic        head_valid;
   logic        pop_en;
   logic        gate_q;

   prx_fifo
   #(
      .WIDTH ($bits(prx_word_t)),
      .DEPTH (PRX_FIFO_DEPTH)
   )
   u_fifo
   (
      .clk       (clk),
      .rstn      (rstn),
      .in_data   (rx_word),
      .in_valid  (rx_word_valid),
      .in_ready  (rx_word_ready),
      .out_data  (head_word),
      .out_valid (head_valid),
      .out_ready (pop_en)
   );

   logic rd_data;
   logic rd_size;

   assign rd_data = reg_req.rd & (reg_req.addr == PRX_ADDR_RX_DATA_POP);
   assign rd_size = reg_req.rd & (reg_req.addr == PRX_ADDR_FRAME_SIZE);
   // a generic-SPI read of the data word pops one word while the gate is open and a word is held; bursts just repeat it
   assign pop_en  = rd_data & reg_req.generic_spi & ~gate_q & head_valid;

   // ------------------------------------------------------------
   // frame gate
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         gate_q <= 1'b0;
      end
      else if (pop_en && head_word.last)
      begin
         gate_q <= 1'b1;
      end
      else if (rd_size && reg_req.generic_spi)
      begin
         gate_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // statistics tallies
   // ------------------------------------------------------------
   logic [PRX_NUM_TALLY-1:0] inc;
   logic [31:0]              tally_q [PRX_NUM_TALLY];
   logic                     rx_drop;

   // a flooded frame only counts as dropped when both targets are full
   assign rx_drop = rx_event.flooded ? (rx_event.host_fifo_full & rx_event.port_fifo_full)
                                     : rx_event.host_fifo_full;

   always_comb
   begin
      inc                 = '0;
      inc[PRX_T_RX_FRM]   = rx_event.valid;
      inc[PRX_T_RX_BC]    = rx_event.valid & rx_event.broadcast;
      inc[PRX_T_RX_MC]    = rx_event.valid & rx_event.multicast & ~rx_event.broadcast;
      inc[PRX_T_RX_UC]    = rx_event.valid & ~rx_event.multicast & ~rx_event.broadcast;
      inc[PRX_T_RX_FCS]   = rx_event.valid & (rx_event.fcs_err | rx_event.phy_err);
      inc[PRX_T_RX_ALIGN] = rx_event.valid & rx_event.align_err;
      inc[PRX_T_RX_LEN]   = rx_event.valid & rx_event.length_err;
      inc[PRX_T_RX_PHY]   = 1'b0;
      inc[PRX_T_TX_FRM]   = tx_event.valid;
      inc[PRX_T_TX_BC]    = tx_event.valid & tx_event.broadcast;
      inc[PRX_T_TX_MC]    = tx_event.valid & tx_event.multicast & ~tx_event.broadcast;
      inc[PRX_T_TX_UC]    = tx_event.valid & ~tx_event.multicast & ~tx_event.broadcast;
      inc[PRX_T_RX_DROP]  = rx_event.valid & rx_drop;
   end

   // free-running, writes never reach them
   genvar gi;
   generate
      for (gi = 0; gi < PRX_NUM_TALLY; gi++)
      begin : g_tally
         always_ff @(posedge clk)
         begin
            if (!rstn)
            begin
               tally_q[gi] <= PRX_TALLY_RESET;
            end
            else if (inc[gi])
            begin
               tally_q[gi] <= tally_q[gi] + 32'h0000_0001;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   logic [31:0] rdata_d;

   always_comb
   begin
      rdata_d = PRX_DATA_RESET;
      case (reg_req.addr)
         PRX_ADDR_FRAME_SIZE:   rdata_d = {21'h0, head_frame_byte_length};
         PRX_ADDR_RX_DATA_POP:  rdata_d = pop_en ? head_word.data : PRX_DATA_RESET;
         PRX_ADDR_RX_FRAMES:    rdata_d = tally_q[PRX_T_RX_FRM];
         PRX_ADDR_RX_BCAST:     rdata_d = tally_q[PRX_T_RX_BC];
         PRX_ADDR_RX_MCAST:     rdata_d = tally_q[PRX_T_RX_MC];
         PRX_ADDR_RX_UCAST:     rdata_d = tally_q[PRX_T_RX_UC];
         PRX_ADDR_RX_FCS_ERR:   rdata_d = tally_q[PRX_T_RX_FCS];
         PRX_ADDR_RX_ALIGN_ERR: rdata_d = tally_q[PRX_T_RX_ALIGN];
         PRX_ADDR_RX_LEN_ERR:   rdata_d = tally_q[PRX_T_RX_LEN];
         PRX_ADDR_RX_PHY_ERR:   rdata_d = tally_q[PRX_T_RX_PHY];
         PRX_ADDR_TX_FRAMES:    rdata_d = tally_q[PRX_T_TX_FRM];
         PRX_ADDR_TX_BCAST:     rdata_d = tally_q[PRX_T_TX_BC];
         PRX_ADDR_TX_MCAST:     rdata_d = tally_q[PRX_T_TX_MC];
         PRX_ADDR_TX_UCAST:     rdata_d = tally_q[PRX_T_TX_UC];
         PRX_ADDR_RX_FULL_DROP: rdata_d = tally_q[PRX_T_RX_DROP];
         default:               rdata_d = PRX_DATA_RESET;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         reg_rdata  <= PRX_DATA_RESET;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_req.rd;
         if (reg_req.rd)
         begin
            reg_rdata <= rdata_d;
         end
      end
   end
endmodule

// *** dv/prx_rx_pop_stats_properties.sv ***
`timescale 1ns/10ps
module prx_rx_pop_stats_properties
   import prx_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  rstn,
   input wire prx_reg_req_t          reg_req,
   input wire logic [31:0]           reg_rdata,
   input wire logic                  reg_rvalid,
   input wire logic                  rx_word_ready,
   input wire logic [PRX_SIZE_W-1:0] head_frame_byte_length,
   input wire prx_rx_event_t         rx_event
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic pop_rd;
   assign pop_rd = reg_req.rd && reg_req.addr == PRX_ADDR_RX_DATA_POP;
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   a_read_answered: assert property (reg_req.rd |=> reg_rvalid)
      else $error("read not answered");
   a_no_stray_answer: assert property (!reg_req.rd |=> !reg_rvalid)
      else $error("answer without read");
   a_burst_answers: assert property (reg_req.rd [*2] |-> reg_rvalid [*2])
      else $error("burst answers missing");
   a_framed_pop_zero: assert property (pop_rd && !reg_req.generic_spi |=> reg_rdata == '0)
      else $error("framed mode pop returned data");
   a_phy_tally_zero: assert property (reg_req.rd && reg_req.addr == PRX_ADDR_RX_PHY_ERR
      |=> reg_rdata == '0)
      else $error("phy error tally moved");
   a_size_readback: assert property (reg_req.rd && reg_req.addr == PRX_ADDR_FRAME_SIZE
      |=> reg_rdata == {21'h0, $past(head_frame_byte_length)})
      else $error("frame size readback wrong");
   a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
   a_unmapped_zero: assert property (reg_req.rd && reg_req.addr inside {[8'hC2:8'hCF]}
      |=> reg_rdata == '0)
      else $error("unmapped read not zero");
   c_pop: cover property (pop_rd && reg_req.generic_spi);
   c_event: cover property (rx_event.valid);
   c_full: cover property (!rx_word_ready);
endmodule
bind prx_rx_pop_stats prx_rx_pop_stats_properties prx_rx_pop_stats_properties_i
   (.clk(clk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .rx_word_ready(rx_word_ready),
    .head_frame_byte_length(head_frame_byte_length), .rx_event(rx_event));

// *** dv/prx_word_source.sv ***
`timescale 1ns/10ps
module prx_word_source
   import prx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [4:0]  n_words,
   input  wire logic [31:0] base,
   input  wire logic        ready,
   output      prx_word_t   word,
   output      logic        valid
);
   logic [4:0] sent_q;
   always_ff @(posedge clk)
   begin
      if (!rstn)
         sent_q <= 5'h00;
      else if (valid && ready)
         sent_q <= sent_q + 5'h01;
   end
   // stalls once n_words sent; idle lines show the inverse
   assign valid = rstn && sent_q < n_words;
   assign word  = '{data: valid ? base + 32'(sent_q) : ~(base + 32'(sent_q)),
                    last: sent_q[1:0] == 2'h3};
endmodule

// *** dv/prx_rx_pop_stats_tb.sv ***
`timescale 1ns/10ps
module prx_rx_pop_stats_tb;
   import prx_pkg::*;
   logic                  clk;
   logic                  rstn;
   prx_reg_req_t          reg_req;
   logic [31:0]           reg_rdata;
   logic                  reg_rvalid;
   prx_word_t             rx_word;
   logic                  rx_word_valid;
   logic                  rx_word_ready;
   logic [PRX_SIZE_W-1:0] hfl;
   prx_rx_event_t         rx_event;
   prx_rx_event_t         ev;
   prx_tx_event_t         tx_event;
   prx_tx_event_t         tv;
   logic [4:0]            n_words;
   logic [31:0]           base;
   logic [31:0]           tally[13];
   logic [31:0]           exp_q[$];
   int                    n_mismatch;
   int                    checks;
   int                    i;
   int                    f;
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   prx_rx_pop_stats prx_rx_pop_stats_i (.clk(clk), .rstn(rstn), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_word(rx_word),
      .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready),
      .head_frame_byte_length(hfl), .rx_event(rx_event), .tx_event(tx_event));
   prx_word_source prx_word_source_i (.clk(clk), .rstn(rstn), .n_words(n_words),
      .base(base), .ready(rx_word_ready), .word(rx_word), .valid(rx_word_valid));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
      checks++;
      if (seen !== expv)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, expv, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic g, input logic [31:0] e);
      @(posedge clk);
      reg_req <= '{rd: 1'b1, wr: 1'b0, addr: a, generic_spi: g};
      exp_q.push_back(e);
   endtask
   task automatic drain(input string name);
      @(posedge clk);
      reg_req <= '0;
      for (int n = 0; n < 20 && exp_q.size() > 0; n++)
         @(posedge clk);
      check(32'(exp_q.size()), 32'h0000_0000, "pending reads");
      $display("test %s done", name);
   endtask
   // ----------------------------------------
   // result monitor
   // ----------------------------------------
   always @(posedge clk)
   begin
      if (reg_rvalid === 1'b1)
         check(reg_rdata, exp_q.size() > 0 ? exp_q.pop_front() : ~reg_rdata, "read data");
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      rstn = 1'b0;
      reg_req = '0;
      rx_event = '0;
      tx_event = '0;
      n_words = 5'h00;
      n_mismatch = 0;
      checks = 0;
      void'($urandom(32'h7F8FB494));
      base = $urandom;
      hfl = 11'($urandom);
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      for (i = 0; i < 13; i++)
         rd(PRX_ADDR_RX_FRAMES + 8'(i), 1'b1, PRX_TALLY_RESET);
      rd(PRX_ADDR_RX_DATA_POP, 1'b1, PRX_DATA_RESET);
      rd(8'hC5, 1'b1, 32'h0000_0000);
      drain("reset");
      n_words <= 5'h14;
      for (i = 0; i < 60 && rx_word_ready !== 1'b0; i++)
         @(posedge clk);
      check(32'(rx_word_ready), 32'h0000_0000, "fifo full");
      for (f = 0; f < 5; f++)
      begin
         rd(PRX_ADDR_FRAME_SIZE, 1'b1, {21'h0, hfl});
         rd(PRX_ADDR_RX_DATA_POP, 1'b0, 32'h0000_0000);
         for (i = 0; i < 4; i++)
            rd(PRX_ADDR_RX_DATA_POP, 1'b1, base + 32'(4 * f + i));
         rd(PRX_ADDR_RX_DATA_POP, 1'b1, 32'h0000_0000);
         rd(PRX_ADDR_FRAME_SIZE, 1'b0, {21'h0, hfl});
         rd(PRX_ADDR_RX_DATA_POP, 1'b1, 32'h0000_0000);
      end
      drain("fifo pop");
      tally = '{default: 32'h0000_0000};
      repeat (80)
      begin
         @(posedge clk);
         ev = 10'($urandom);
         tv = 3'($urandom);
         rx_event <= ev;
         tx_event <= tv;
         reg_req <= '{rd: 1'b0, wr: 1'b1, addr: 8'($urandom), generic_spi: 1'b1};
         if (ev.valid)
         begin
            tally[0]++;
            tally[ev.broadcast ? 1 : ev.multicast ? 2 : 3]++;
            tally[4] += 32'(ev.fcs_err | ev.phy_err);
            tally[5] += 32'(ev.align_err);
            tally[6] += 32'(ev.length_err);
            tally[12] += 32'(ev.flooded ? ev.host_fifo_full & ev.port_fifo_full
                                        : ev.host_fifo_full);
         end
         if (tv.valid)
         begin
            tally[8]++;
            tally[tv.broadcast ? 9 : tv.multicast ? 10 : 11]++;
         end
      end
      @(posedge clk);
      rx_event <= '0;
      tx_event <= '0;
      for (i = 0; i < 13; i++)
         rd(PRX_ADDR_RX_FRAMES + 8'(i), 1'b1, tally[i]);
      drain("tallies");
      print_verdict();
   end
endmodule
